// ### core/rht_pkg.sv
// Purpose: Shared constants for the humidity and temperature sensor slave.
// Assumes: System clock of 125 MHz; bus lines arrive from pins.
// Notes:   Counts of cycles are derived from times given in their own unit.
package rht_pkg;

    localparam logic [6:0]  SLAVE_ADDR       = 7'h44;
    localparam logic [7:0]  CMD_PROG_ENTER   = 8'ha0;
    localparam logic [7:0]  CMD_PROG_EXIT    = 8'h80;
    localparam logic [7:0]  REG_HUM_RES_RD   = 8'h06;
    localparam logic [7:0]  REG_TMP_RES_RD   = 8'h11;
    localparam logic [7:0]  REG_ID_UPPER     = 8'h1e;
    localparam logic [7:0]  REG_ID_LOWER     = 8'h1f;
    localparam logic [7:0]  REG_HUM_RES_WR   = 8'h46;
    localparam logic [7:0]  REG_TMP_RES_WR   = 8'h51;
    localparam int          RES_MSB          = 11;
    localparam int          RES_LSB          = 10;
    localparam logic [15:0] RES_REG_RESET    = 16'h0c00;
    localparam logic [1:0]  STATUS_VALID     = 2'b00;
    localparam logic [1:0]  STATUS_STALE     = 2'b01;
    localparam int          CLOCK_MHZ        = 125;
    localparam int          PROG_WINDOW_MS   = 10;
    localparam int          PROG_WINDOW_CYC  = PROG_WINDOW_MS * 1000 * CLOCK_MHZ;
    localparam int          WAKE_US          = 100;
    localparam int          WAKE_CYC         = WAKE_US * CLOCK_MHZ;
    // Conversion time of one quantity per resolution code, in microseconds.
    localparam int          CONV_US_8        = 550;
    localparam int          CONV_US_10       = 1310;
    localparam int          CONV_US_12       = 4500;
    localparam int          CONV_US_14       = 16900;
    localparam int          PROC_US          = 120;
    localparam int          PROC_CYC         = PROC_US * CLOCK_MHZ;

endpackage

// ### core/rht_sensor_slave.sv
// Summary of operation
// - Acts only as bus slave; link logic runs at either bit rate.
// - Acknowledges only address 44 hex, ignores all other addresses.
// - Data sampled on rising clock; data change at clock high is start/stop.
// - Seven address bits then direction bit: one reads, zero writes.
// - Eight bits then a response bit; low acknowledges, high refuses.
// - Starts asleep; converts only on measurement request, else powered down.
// - Address with write bit and no more bytes starts one measurement.
// - Humidity, then temperature; each output updated as its conversion ends.
// - Results are fourteen bits and sent most significant byte first.
// - Address with read bit is acknowledged and returns measurement bytes.
// - Byte one carries status in top bits, then fourteen humidity bits.
// - Bytes three and four carry temperature left aligned, low two undefined.
// - Cycle time follows resolution plus the wake-up time.
// - Status reads 00 before fetch since measurement, 01 after.
// - Fetch before first measurement completes reports the stale code.
// - Command A0 00 00 within ten milliseconds enters programming mode.
// - Entry command takes 120 microseconds before registers are reachable.
// - Command 80 00 00 leaves programming mode.
// - Resolution fields sit in bits 11:10; read 06/11, written 46/51.
// - Identity readable as upper half at 1E and lower half at 1F.
// - Field codes 8, 10, 12, 14 bits; both default to fourteen.
//
// Purpose: Serial slave front end, measurement sequencer, register store.
// Assumes: Bus lines are synchronised into the link clock domain.
// Notes:   Humidity and temperature samples enter on plain input ports.
`timescale 1ns/1ps
module rht_sensor_slave
    import rht_pkg::*;
#(
    parameter int          PROG_WINDOW = PROG_WINDOW_CYC,
    parameter int          WAKE        = WAKE_CYC,
    parameter int          CONV_SCALE  = CLOCK_MHZ,
    parameter int          PROC        = PROC_CYC,
    parameter logic [31:0] IDENTITY    = 32'h1234abcd // Arbitrary value.
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        link_clock,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic [13:0] humidity_sample,
    input  wire logic [13:0] temperature_sample,
    output logic             core_awake,
    output logic             prog_mode
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_WACK = 3'b010,
        ST_WRX  = 3'b011, ST_RTX  = 3'b100, ST_RACK = 3'b101
    } link_state_t;

    typedef enum logic [1:0] {
        M_SLEEP = 2'b00, M_WAKE = 2'b01, M_HUM = 2'b10, M_TMP = 2'b11
    } meas_state_t;

    // Conversion cycles for one quantity from a resolution code.
    function automatic logic [31:0] conv_cycles(input logic [1:0] code);
        case (code)
            2'b00:   conv_cycles = 32'(CONV_US_8 * CONV_SCALE);
            2'b01:   conv_cycles = 32'(CONV_US_10 * CONV_SCALE);
            2'b10:   conv_cycles = 32'(CONV_US_12 * CONV_SCALE);
            default: conv_cycles = 32'(CONV_US_14 * CONV_SCALE);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain: bus line synchronisers and edge detection.
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_d;
    logic        sda_d;
    link_state_t lstate;
    logic [3:0]  bitcnt;
    logic [7:0]  shifter;
    logic        rw;
    logic [1:0]  wbytes;
    logic [7:0]  wbuf [0:2];
    logic [1:0]  rbyte;
    logic        frame_end_tgl;
    logic        fetch_tgl;
    logic        addr_match_tgl;

    // Pins pass two flip-flops before use.
    // slave pin sampling.
    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    wire scl_s    = scl_sync[1];
    wire sda_s    = sda_sync[1];
    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Core domain values carried to the link; stable while a frame runs.
    ////////////////////////////////////////////////////////////////////////
    logic [1:0]  status;
    logic [13:0] hum_out;
    logic [13:0] tmp_out;
    logic [15:0] reg_hold;
    logic        prog;

    logic [1:0]  status_l0;
    logic [1:0]  status_l;
    wire  [7:0]  rd_byte_meas = (rbyte == 2'd0) ? {status_l, hum_out[13:8]} :
                                (rbyte == 2'd1) ? hum_out[7:0] :
                                (rbyte == 2'd2) ? tmp_out[13:6] :
                                                  {tmp_out[5:0], 2'b00};
    wire  [7:0]  rd_byte_reg  = rbyte[0] ? reg_hold[7:0] : reg_hold[15:8];
    wire  [7:0]  rd_byte      = prog ? rd_byte_reg : rd_byte_meas;
    wire  [7:0]  next_shift   = {shifter[6:0], sda_s};
    // address compare.
    // The shifter already holds all eight bits when the decision is taken.
    wire         addr_ok      = (shifter[7:1] == SLAVE_ADDR);

    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            status_l0 <= STATUS_STALE;
            status_l  <= STATUS_STALE;
        end else begin
            status_l0 <= status;
            status_l  <= status_l0;
        end
    end

    // byte framing with acknowledge; direction capture.
    always_ff @(posedge link_clock or negedge rst_n) begin
        if (!rst_n) begin
            lstate         <= ST_IDLE;
            bitcnt         <= 4'd0;
            shifter        <= 8'h00;
            rw             <= 1'b0;
            wbytes         <= 2'd0;
            rbyte          <= 2'd0;
            sda_out        <= 1'b1;
            sda_oe_n       <= 1'b1;
            frame_end_tgl  <= 1'b0;
            fetch_tgl      <= 1'b0;
            addr_match_tgl <= 1'b0;
            wbuf[0]        <= 8'h00;
            wbuf[1]        <= 8'h00;
            wbuf[2]        <= 8'h00;
        end else if (start_c) begin
            lstate   <= ST_ADDR;
            bitcnt   <= 4'd0;
            wbytes   <= 2'd0;
            rbyte    <= 2'd0;
            sda_oe_n <= 1'b1;
        end else if (stop_c) begin
            if (lstate != ST_IDLE && lstate != ST_ADDR && !rw)
                frame_end_tgl <= ~frame_end_tgl;
            lstate   <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            case (lstate)
                ST_ADDR, ST_WRX: if (scl_rise) begin
                    shifter <= next_shift;
                    bitcnt  <= bitcnt + 4'd1;
                end else if (scl_fall && bitcnt == 4'd8) begin
                    bitcnt <= 4'd0;
                    if (lstate == ST_ADDR) begin
                        if (addr_ok) begin
                            rw             <= shifter[0];
                            addr_match_tgl <= ~addr_match_tgl;
                            sda_out        <= 1'b0;
                            sda_oe_n       <= 1'b0;
                            lstate         <= ST_WACK;
                        end else begin
                            lstate <= ST_IDLE;
                        end
                    end else begin
                        if (wbytes != 2'd3) begin
                            wbuf[wbytes] <= shifter;
                            wbytes       <= wbytes + 2'd1;
                        end
                        sda_out  <= 1'b0;
                        sda_oe_n <= 1'b0;
                        lstate   <= ST_WACK;
                    end
                end
                ST_WACK: if (scl_fall) begin
                    if (rw) begin
                        fetch_tgl <= ~fetch_tgl;
                        sda_out   <= rd_byte[7];
                        sda_oe_n  <= 1'b0;
                        shifter   <= {rd_byte[6:0], 1'b0};
                        bitcnt    <= 4'd1;
                        lstate    <= ST_RTX;
                    end else begin
                        sda_oe_n <= 1'b1;
                        lstate   <= ST_WRX;
                    end
                end
                ST_RTX: if (scl_fall) begin
                    if (bitcnt == 4'd8) begin
                        sda_oe_n <= 1'b1;
                        lstate   <= ST_RACK;
                    end else begin
                        sda_out <= shifter[7];
                        shifter <= {shifter[6:0], 1'b0};
                        bitcnt  <= bitcnt + 4'd1;
                    end
                end
                ST_RACK: if (scl_rise) begin
                    if (sda_s) begin
                        lstate <= ST_IDLE;
                    end else begin
                        rbyte  <= rbyte + 2'd1;
                        lstate <= ST_WACK;
                    end
                end
                default: lstate <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: event crossings, measurement sequencer, registers.
    ////////////////////////////////////////////////////////////////////////
    logic [2:0]  end_sync;
    logic [2:0]  fetch_sync;
    logic [1:0]  res_hum;
    logic [1:0]  res_tmp;
    logic [15:0] hum_reg;
    logic [15:0] tmp_reg;
    meas_state_t mstate;
    logic [31:0] timer;
    logic [31:0] age;
    logic        window_open;
    logic [31:0] proc_cnt;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            end_sync   <= 3'b000;
            fetch_sync <= 3'b000;
        end else begin
            end_sync   <= {end_sync[1:0], frame_end_tgl};
            fetch_sync <= {fetch_sync[1:0], fetch_tgl};
        end
    end

    // Frame words are stable after stop, so read once the event arrives.
    wire frame_done = end_sync[2] ^ end_sync[1];
    wire fetch_ev   = fetch_sync[2] ^ fetch_sync[1];
    wire [1:0] nb   = wbytes;
    wire is_mr      = frame_done && nb == 2'd0 && !prog;
    wire cmd3       = frame_done && nb == 2'd3;
    wire is_enter   = cmd3 && window_open && wbuf[0] == CMD_PROG_ENTER &&
                      wbuf[1] == 8'h00 && wbuf[2] == 8'h00;
    wire is_exit    = cmd3 && prog && wbuf[0] == CMD_PROG_EXIT &&
                      wbuf[1] == 8'h00 && wbuf[2] == 8'h00;
    wire prog_ready = prog && proc_cnt == 32'd0;
    wire reg_cmd    = cmd3 && prog_ready && !is_exit;
    wire meas_done  = mstate == M_TMP && timer == 32'd0;

    wire [15:0] reg_sel = (wbuf[0] == REG_HUM_RES_RD) ? hum_reg :
                          (wbuf[0] == REG_TMP_RES_RD) ? tmp_reg :
                          (wbuf[0] == REG_ID_UPPER)   ? IDENTITY[31:16] :
                          (wbuf[0] == REG_ID_LOWER)   ? IDENTITY[15:0] :
                                                        16'h0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            window_open <= 1'b1;
            age         <= 32'd0;
            prog        <= 1'b0;
            proc_cnt    <= 32'd0;
            hum_reg     <= RES_REG_RESET;
            tmp_reg     <= RES_REG_RESET;
            reg_hold    <= 16'h0000;
        end else begin
            if (age != 32'(PROG_WINDOW))
                age <= age + 32'd1;
            else
                window_open <= 1'b0;
            if (is_enter) begin
                prog     <= 1'b1;
                proc_cnt <= 32'(PROC);
            end else if (is_exit) begin
                prog <= 1'b0;
            end else if (proc_cnt != 32'd0) begin
                proc_cnt <= proc_cnt - 32'd1;
            end
            if (reg_cmd && wbuf[0] == REG_HUM_RES_WR)
                hum_reg <= {wbuf[1], wbuf[2]};
            if (reg_cmd && wbuf[0] == REG_TMP_RES_WR)
                tmp_reg <= {wbuf[1], wbuf[2]};
            if (reg_cmd)
                reg_hold <= reg_sel;
        end
    end

    assign res_hum = hum_reg[RES_MSB:RES_LSB];
    assign res_tmp = tmp_reg[RES_MSB:RES_LSB];

    // sleep sequencer; humidity then temperature; timing.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mstate     <= M_SLEEP;
            timer      <= 32'd0;
            hum_out    <= 14'h0000;
            tmp_out    <= 14'h0000;
            core_awake <= 1'b0;
        end else begin
            case (mstate)
                M_SLEEP: if (is_mr) begin
                    mstate     <= M_WAKE;
                    timer      <= 32'(WAKE);
                    core_awake <= 1'b1;
                end
                M_WAKE: if (timer == 32'd0) begin
                    mstate <= M_HUM;
                    timer  <= conv_cycles(res_hum);
                end else begin
                    timer <= timer - 32'd1;
                end
                M_HUM: if (timer == 32'd0) begin
                    hum_out <= humidity_sample;
                    mstate  <= M_TMP;
                    timer   <= conv_cycles(res_tmp);
                end else begin
                    timer <= timer - 32'd1;
                end
                M_TMP: if (timer == 32'd0) begin
                    tmp_out    <= temperature_sample;
                    mstate     <= M_SLEEP;
                    core_awake <= 1'b0;
                end else begin
                    timer <= timer - 32'd1;
                end
                default: mstate <= M_SLEEP;
            endcase
        end
    end

    // fresh then stale; stale from reset; completion wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            status <= STATUS_STALE;
        else if (meas_done)
            status <= STATUS_VALID;
        else if (fetch_ev && !prog)
            status <= STATUS_STALE;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            prog_mode <= 1'b0;
        else
            prog_mode <= prog;
    end

    // Assertions.
    property p_status_fresh;
        @(posedge clock) disable iff (!rst_n)
        meas_done |=> status == STATUS_VALID;
    endproperty
    a_status_fresh: assert property (p_status_fresh)
        else $error("status not valid after measurement");

    property p_sleep_start;
        @(posedge clock) disable iff (!rst_n)
        (mstate == M_SLEEP && !is_mr) |=> mstate == M_SLEEP;
    endproperty
    a_sleep_start: assert property (p_sleep_start)
        else $error("core woke without request");

    property p_hum_then_tmp;
        @(posedge clock) disable iff (!rst_n)
        (mstate == M_HUM && timer == 32'd0) |=> mstate == M_TMP;
    endproperty
    a_hum_then_tmp: assert property (p_hum_then_tmp)
        else $error("temperature did not follow humidity");

    property p_nack_addr;
        @(posedge link_clock) disable iff (!rst_n)
        (lstate == ST_ADDR && scl_fall && bitcnt == 4'd8 && !addr_ok &&
         !start_c && !stop_c) |=> sda_oe_n;
    endproperty
    a_nack_addr: assert property (p_nack_addr)
        else $error("foreign address acknowledged");

    property p_enter_late;
        @(posedge clock) disable iff (!rst_n)
        (!window_open && !prog) |=> !prog;
    endproperty
    a_enter_late: assert property (p_enter_late)
        else $error("programming mode entered late");

    property p_exit;
        @(posedge clock) disable iff (!rst_n)
        is_exit |=> !prog;
    endproperty
    a_exit: assert property (p_exit)
        else $error("programming mode not left");

    property p_proc;
        @(posedge clock) disable iff (!rst_n)
        is_enter |=> !prog_ready;
    endproperty
    a_proc: assert property (p_proc)
        else $error("registers reachable too early");

    property p_res_default;
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> res_hum == 2'b11 && res_tmp == 2'b11;
    endproperty
    a_res_default: assert property (p_res_default)
        else $error("resolution default not fourteen bits");

endmodule // rht_sensor_slave

// ### test/bus_master_model.sv
// Purpose: Behavioural two-wire bus master facing the sensor slave.
// Assumes: Both lines are open drain with pull-ups; released reads high.
// Notes:   A 900 ns bit keeps the link clock above sixteen per bus bit.
`timescale 1ns/1ps
module bus_master_model (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    localparam time H = 400;
    localparam time Q = 100;

    // Both lines are released while the bus is idle.
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    // start condition
    // Data falls while the clock is high, also for a repeated start.
    task automatic start();
        #Q sda_m = 1'b1;
        #H scl = 1'b1;
        #H sda_m = 1'b0;
        #H scl = 1'b0;
    endtask

    // data held stable
    // Data moves 100 ns into the 500 ns low phase, never while clock is high.
    task automatic put_bit(input logic b);
        #Q sda_m = b;
        #H scl = 1'b1;
        #H scl = 1'b0;
    endtask

    // The master lets go of the line and samples it mid high phase.
    task automatic get_bit(output logic b);
        #Q sda_m = 1'b1;
        #H scl = 1'b1;
        #(H/2) b = sda;
        #(H/2) scl = 1'b0;
    endtask

    // byte then answer
    // Eight bits, most significant first, then the slave's answer bit.
    task automatic wr(input logic [7:0] d, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(r);
        acked = ~r;
    endtask

    // read and refuse
    // Eight bits in, then an acknowledge or, on the last byte, a refusal.
    task automatic rd(input logic last, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(last);
    endtask

    // stop condition
    // Data rises while the clock is high and the bus goes idle.
    task automatic stop();
        #Q sda_m = 1'b0;
        #H scl = 1'b1;
        #H sda_m = 1'b1;
        #H;
    endtask
endmodule // bus_master_model

// ### test/tb_top.sv
// Purpose: Self-checking bench for the sensor slave over its serial bus.
// Assumes: Counts are shortened through the design's parameters.
// Notes:   Temperature byte four is masked in its two low bits.
`timescale 1ns/1ps
module tb_top
    import rht_pkg::*;
;
    localparam int          P_WIN  = 10000;
    localparam int          P_WAKE = 10;
    localparam int          P_PROC = 20;
    localparam logic [31:0] ID     = 32'h5a3c96e1; // Arbitrary value.
    localparam logic [13:0] HUM    = 14'h2a5c;
    localparam logic [13:0] TMP    = 14'h1b37;
    localparam int          LIMIT  = 99000;

    logic clock, rst_n, link_clock, scl, sda_m;
    logic sda_out, sda_oe_n, core_awake, prog_mode, ack;
    logic [15:0] v;
    logic [31:0] d;
    wire         sda_line;
    int          failures = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n;
    logic [7:0]  rd_addr [4] = '{REG_HUM_RES_RD, REG_TMP_RES_RD,
                                 REG_ID_UPPER, REG_ID_LOWER};
    logic [15:0] rd_exp [4] = '{RES_REG_RESET, RES_REG_RESET,
                                ID[31:16], ID[15:0]};
    logic [7:0]  wr_addr [2] = '{REG_HUM_RES_WR, REG_TMP_RES_WR};
    logic [1:0]  code [2] = '{2'b00, 2'b10};

    // The wire is low when either party pulls it low.
    assign sda_line = sda_m & (sda_oe_n | sda_out);

    bus_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda_line));

    rht_sensor_slave #(.PROG_WINDOW(P_WIN), .WAKE(P_WAKE), .CONV_SCALE(1),
                       .PROC(P_PROC), .IDENTITY(ID)) dut (
        .clock(clock), .rst_n(rst_n), .link_clock(link_clock),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .humidity_sample(HUM),
        .temperature_sample(TMP), .core_awake(core_awake),
        .prog_mode(prog_mode));

    ////////////////////////////////////////////////////////////////////////
    // Core clock and an unrelated link clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        link_clock = 1'b0;
        #7;
        forever #24 link_clock = ~link_clock;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clock);
    endtask

    // Address with write bit, then k bytes of x, high byte first.
    task automatic send(input logic [6:0] a, input logic [23:0] x,
                        input int k, output logic acked);
        logic dummy;
        m.start();
        m.wr({a, 1'b0}, acked);
        for (int i = 0; i < k; i++) begin
            m.wr(x[23-8*i -: 8], dummy);
        end
        m.stop();
    endtask

    // Address with read bit, then k bytes, refusing the last.
    task automatic fetch(input int k, output logic [31:0] x);
        logic       a;
        logic [7:0] b;
        x = '0;
        m.start();
        m.wr({SLAVE_ADDR, 1'b1}, a);
        check("fetch_ack", 1, a);
        for (int i = 0; i < k; i++) begin
            m.rd(i == k - 1, b);
            x[31-8*i -: 8] = b;
        end
        m.stop();
    endtask

    // Register read: address with two zero bytes, wait, two byte read.
    task automatic reg_read(input logic [7:0] r, output logic [15:0] x);
        logic        a;
        logic [31:0] y;
        send(SLAVE_ADDR, {r, 16'h0000}, 3, a);
        idle(2 * P_PROC);
        fetch(2, y);
        x = y[31:16];
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence of bus transactions.
    initial begin
        rst_n = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        check("awake_reset", 0, core_awake);
        check("oe_reset", 1, sda_oe_n);
        idle(30);
        send(7'h45, 24'h0, 0, ack);
        check("foreign_ack", 0, ack);
        send(SLAVE_ADDR, {CMD_PROG_ENTER, 16'h0000}, 3, ack);
        idle(4);
        check("prog_enter", 1, prog_mode);
        send(SLAVE_ADDR, 24'h0, 0, ack);
        idle(4);
        check("awake_in_prog", 0, core_awake);
        idle(2 * P_PROC);
        for (int i = 0; i < 4; i++) begin
            reg_read(rd_addr[i], v);
            check("reg_read", rd_exp[i], v);
        end
        for (int i = 0; i < 2; i++) begin
            v = rd_exp[i];
            v[RES_MSB:RES_LSB] = code[i];
            send(SLAVE_ADDR, {wr_addr[i], v}, 3, ack);
            idle(2 * P_PROC);
            reg_read(rd_addr[i], d[15:0]);
            check("reg_write", v, d[15:0]);
        end
        send(SLAVE_ADDR, {CMD_PROG_EXIT, 16'h0000}, 3, ack);
        idle(4);
        check("prog_exit", 0, prog_mode);
        fetch(2, d);
        check("status_first", STATUS_STALE, d[31:30]);
        send(SLAVE_ADDR, 24'h0, 0, ack);
        check("request_ack", 1, ack);
        check("awake_start", 1, core_awake);
        n = 0;
        while (core_awake === 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        check("awake_end", 0, core_awake);
        check("cycle_time", 1, n + 64 >= P_WAKE + CONV_US_8 + CONV_US_12);
        fetch(4, d);
        check("fetch_data", {STATUS_VALID, HUM, TMP, 2'b00},
              d & 32'hffff_fffc);
        fetch(2, d);
        check("status_stale", {STATUS_STALE, HUM}, d[31:16]);
        send(SLAVE_ADDR, {CMD_PROG_ENTER, 16'h0000}, 3, ack);
        idle(4);
        check("late_enter", 0, prog_mode);
        summarize();
    end
endmodule // tb_top
